/* File: logic/ddp_top.sv */
// Purpose: dynamics path: rms detectors, gain tables, look-ahead,
//          post gain, subwoofer compressor, reinjection, de-emphasis
// Assumes: one sample pair per i_smp_vld pulse, pulses >= 20 cycles apart
// Notes:   pairs arriving while a sample is in flight are dropped
module ddp_top #(
	parameter int FS_HZ = 48000,
	parameter int DLY_A = 7
) (
	// clock and reset
	input  wire logic      i_core_clk,
	input  wire logic      i_resetn,
	input  wire logic      i_ce,
	// register port
	input  ddp_pkg::ddp_bus_t  i_bus,
	output logic [21:0]    o_rdata,
	// audio in
	input  wire logic      i_smp_vld,
	input  ddp_pkg::ddp_pair_t i_smp,
	input  wire logic      i_deemph_select_aux_input_pin,
	// audio out
	output logic           o_smp_vld,
	output ddp_pkg::ddp_pair_t o_smp,
	output ddp_pkg::ddp_smp_t  o_sub
);
	import ddp_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_MIX  = 4'h1,
		ST_BIQ  = 4'h2,
		ST_DET  = 4'h3,
		ST_LOG  = 4'h4,
		ST_TBL  = 4'h5,
		ST_GAIN = 4'h6,
		ST_POST = 4'h7,
		ST_OUT  = 4'h8
	} ddp_st_e;

	typedef struct packed {
		ddp_st_e               st;
		logic [1:0]            pin;
		logic [14:0][21:0]     prm;
		logic [21:0]           rdata;
		ddp_pair_t             in;
		ddp_pair_t             dl;
		ddp_pair_t             wk;
		ddp_smp_t              mid;
		ddp_smp_t              w;
		ddp_smp_t              sub;
		ddp_smp_t              osub;
		logic [3:0][23:0]      bq;
		logic [1:0][47:0]      pw;
		logic [1:0][47:0]      env;
		logic [1:0][29:0]      held;
		logic [1:0][21:0]      hcnt;
		logic [3:0][21:0]      tb;
		logic [2:0]            cnt;
		logic [DLY_A-1:0]      ptr;
		logic                  dvld;
	} ddp_top_st_t;

	localparam longint   REL_STEP = (REL_MDB * (64'h1 << LVL_FRAC)) / (IDX_MDB * FS_HZ);
	localparam ddp_coef_t UNITY   = 22'h100000;

	ddp_top_st_t q, d;

	logic [6:0]         tbl_ra;
	logic [21:0]        tbl_rd;
	logic [DLY_A-1:0]   dly_ra;
	logic [47:0]        dly_rd;
	logic [21:0]        dly;
	ddp_dm_e            dm_sel;
	logic signed [55:0] acc;
	logic signed [71:0] dv;
	logic [29:0]        lv;
	logic [29:0]        dec;
	logic [5:0]         ix [2];
	logic [7:0]         fr [2];
	ddp_coef_t          g [2];
	logic signed [31:0] gd;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [29:0] lg(logic [47:0] p);
		logic [5:0]  m;
		logic [47:0] s;
		m = '0;
		for (int i = 0; i < 48; i++)
			if (p[i])
				m = 6'(i);
		s = p << (6'd47 - m);
		return {m, s[46:23]};
	endfunction : lg

	// level to table index, 3 dB of power per index step
	function automatic logic [5:0] tidx(logic [29:0] h);
		if (h[29:24] < TBL_OFS)
			return '0;
		if (h[29:24] - TBL_OFS >= GAIN_LAST)
			return GAIN_LAST;
		return h[29:24] - TBL_OFS;
	endfunction : tidx

	// ----------------------------------------------------------------
	// memories
	// ----------------------------------------------------------------
	ddp_mem #(.W(22), .A(7)) u_tbl (
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.i_ce       (i_ce),
		.i_we       (i_bus.wr && i_bus.addr[TBL_SEL_BIT]),
		.i_waddr    (i_bus.addr[6:0]),
		.i_wdata    (i_bus.wdata),
		.i_raddr    (tbl_ra),
		.o_rdata    (tbl_rd)
	);

	ddp_mem #(.W(48), .A(DLY_A)) u_dly (
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.i_ce       (i_ce),
		.i_we       (q.st == ST_IDLE && i_smp_vld),
		.i_waddr    (q.ptr),
		.i_wdata    (i_smp),
		.i_raddr    (dly_ra),
		.o_rdata    (dly_rd)
	);

	// clamp guards against an over-range load
	assign dly = (q.prm[REG_LOOKAHD] > LOOKAHD_MAX) ? LOOKAHD_MAX : q.prm[REG_LOOKAHD];
	assign dly_ra = q.ptr - dly[DLY_A-1:0];

	// pin wins over the register field while high
	assign dm_sel = q.pin[1] ? DM_44K1 : ddp_dm_e'(q.prm[REG_CTRL1][DM_LSB+:2]);

	always_comb begin
		for (int k = 0; k < 2; k++) begin
			ix[k] = tidx(q.held[k]);
			fr[k] = (ix[k] == GAIN_LAST || q.held[k][29:24] < TBL_OFS) ? 8'h00
				: q.held[k][23:16];
			gd = 32'(signed'(q.tb[2*k+1])) - 32'(signed'(q.tb[2*k]));
			// signed product so a falling curve interpolates downward
			gd = (gd * signed'(32'(fr[k]))) >>> 8;
			g[k] = q.tb[2*k] + gd[21:0];
		end
		unique case (q.cnt[1:0])
			2'h0: tbl_ra = {1'b0, ix[0]};
			2'h1: tbl_ra = {1'b0, (ix[0] == GAIN_LAST) ? ix[0] : ix[0] + 6'h01};
			2'h2: tbl_ra = TBL_SUB + {1'b0, ix[1]};
			2'h3: tbl_ra = TBL_SUB + {1'b0, (ix[1] == GAIN_LAST) ? ix[1] : ix[1] + 6'h01};
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		acc = '0;
		dv = '0;
		lv = '0;
		dec = '0;
		d.dvld = 1'b0;
		d.pin = {q.pin[0], i_deemph_select_aux_input_pin};

		// register port
		if (i_bus.wr && i_bus.addr < NUM_PRM)
			d.prm[i_bus.addr[3:0]] = i_bus.wdata;
		if (i_bus.rd) begin
			if (i_bus.addr < NUM_PRM)
				d.rdata = q.prm[i_bus.addr[3:0]];
			else if (i_bus.addr == REG_LVL_MAIN)
				d.rdata = q.held[0][29:8];
			else if (i_bus.addr == REG_LVL_SUB)
				d.rdata = q.held[1][29:8];
			else
				d.rdata = '0;
		end

		unique case (q.st)
			ST_IDLE: begin
				if (i_smp_vld) begin
					d.in = i_smp;
					d.st = ST_MIX;
				end
			end
			ST_MIX: begin
				d.ptr = q.ptr + 1'b1;
				d.dl = (dly == '0) ? q.in : dly_rd;
				acc = (56'(q.in.l) + 56'(q.in.r)) >>> 1;
				d.mid = acc[23:0];
				acc = q.in.l * ddp_coef_t'(q.prm[REG_LWEIGHT]);
				acc = acc + q.in.r * ddp_coef_t'(q.prm[REG_RWEIGHT]);
				d.w = sat(acc >>> FRAC);
				d.st = ST_BIQ;
			end
			ST_BIQ: begin
				acc = q.w * ddp_coef_t'(q.prm[REG_BQ_B0]);
				acc = acc + ddp_smp_t'(q.bq[0]) * ddp_coef_t'(q.prm[REG_BQ_B1]);
				acc = acc + ddp_smp_t'(q.bq[1]) * ddp_coef_t'(q.prm[REG_BQ_B2]);
				acc = acc - ddp_smp_t'(q.bq[2]) * ddp_coef_t'(q.prm[REG_BQ_A1]);
				acc = acc - ddp_smp_t'(q.bq[3]) * ddp_coef_t'(q.prm[REG_BQ_A2]);
				d.bq[1] = q.bq[0];
				d.bq[0] = q.w;
				d.bq[3] = q.bq[2];
				d.bq[2] = sat(acc >>> FRAC);
				d.st = ST_DET;
			end
			ST_DET: begin
				// biquad output feeds only the detector
				d.pw[0] = 48'(q.mid * q.mid);
				d.pw[1] = 48'(ddp_smp_t'(q.bq[2]) * ddp_smp_t'(q.bq[2]));
				d.st = ST_LOG;
			end
			ST_LOG: begin
				for (int k = 0; k < 2; k++) begin
					// mean-square smoothing, raw release set by the coefficient
					dv = {24'h0, q.pw[k]} - {24'h0, q.env[k]};
					dv = (dv * $signed({50'h0, q.prm[REG_TCONST]})) >>> FRAC;
					d.env[k] = q.env[k] + dv[47:0];
					lv = lg(d.env[k]);
					dec = 30'(q.prm[REG_DECAY] * REL_STEP);
					if (lv > q.held[k]) begin
						d.held[k] = lv;
						d.hcnt[k] = q.prm[REG_HOLD];
					end else if (q.hcnt[k] != '0) begin
						d.hcnt[k] = q.hcnt[k] - 1'b1;
					end else if (q.held[k] - lv > dec) begin
						d.held[k] = q.held[k] - dec;
					end else begin
						d.held[k] = lv;
					end
				end
				d.cnt = '0;
				d.st = ST_TBL;
			end
			ST_TBL: begin
				// four reads pipelined, data lands one cycle after its address
				if (q.cnt != '0)
					d.tb[q.cnt[1:0] - 2'h1] = tbl_rd;
				d.cnt = q.cnt + 1'b1;
				if (q.cnt == 3'h4)
					d.st = ST_GAIN;
			end
			ST_GAIN: begin
				d.wk.l = mulc(q.dl.l, g[0]);
				d.wk.r = mulc(q.dl.r, g[0]);
				d.sub = mulc(q.w, g[1]);
				d.cnt = POST_STAGES;
				d.st = ST_POST;
			end
			ST_POST: begin
				// one stage per cycle tops out near 30 dB
				d.wk.l = mulc(q.wk.l, ddp_coef_t'(q.prm[REG_POSTGAIN]));
				d.wk.r = mulc(q.wk.r, ddp_coef_t'(q.prm[REG_POSTGAIN]));
				d.cnt = q.cnt - 1'b1;
				if (q.cnt == 3'h1)
					d.st = ST_OUT;
			end
			ST_OUT: begin
				acc = 56'(q.wk.l) + 56'(mulc(q.sub, ddp_coef_t'(q.prm[REG_REINJ_L])));
				d.wk.l = sat(acc);
				acc = 56'(q.wk.r) + 56'(mulc(q.sub, ddp_coef_t'(q.prm[REG_REINJ_R])));
				d.wk.r = sat(acc);
				d.osub = q.sub;
				d.dvld = 1'b1;
				d.st = ST_IDLE;
			end
			default: d.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			q <= '0;
			q.prm <= PRM_RST;
		end else if (i_ce) begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// de-emphasis, separate from the biquad bank
	// ----------------------------------------------------------------
	ddp_deemph u_dm (
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.i_ce       (i_ce),
		.i_vld      (q.dvld),
		.i_smp      (q.wk),
		.i_sel      (dm_sel),
		.o_vld      (o_smp_vld),
		.o_smp      (o_smp)
	);

	assign o_rdata = q.rdata;
	assign o_sub = q.osub;

	// unused-gain constant kept for host reference of unity post gain
	logic unused_ok;
	assign unused_ok = (UNITY == PRM_RST[REG_POSTGAIN]);

endmodule : ddp_top

/* File: logic/ddp_pkg.sv */
// Purpose: shared types, register map and constants for the dynamics path
// Assumes: 24-bit signed audio, 22-bit 2.20 coefficients
// Notes:   one aligned register per index, data in the low 22 bits
package ddp_pkg;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef logic signed [23:0] ddp_smp_t;
	typedef logic signed [21:0] ddp_coef_t;

	typedef struct packed {
		ddp_smp_t l;
		ddp_smp_t r;
	} ddp_pair_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [21:0] wdata;
		logic        wr;
		logic        rd;
	} ddp_bus_t;

	typedef enum logic [1:0] {
		DM_BYPASS = 2'h0,
		DM_32K    = 2'h1,
		DM_44K1   = 2'h2,
		DM_48K    = 2'h3
	} ddp_dm_e;

	// ----------------------------------------------------------------
	// register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_TCONST   = 8'h00;
	localparam logic [7:0] REG_HOLD     = 8'h01;
	localparam logic [7:0] REG_DECAY    = 8'h02;
	localparam logic [7:0] REG_LOOKAHD  = 8'h03;
	localparam logic [7:0] REG_POSTGAIN = 8'h04;
	localparam logic [7:0] REG_LWEIGHT  = 8'h05;
	localparam logic [7:0] REG_RWEIGHT  = 8'h06;
	localparam logic [7:0] REG_BQ_B0    = 8'h07;
	localparam logic [7:0] REG_BQ_B1    = 8'h08;
	localparam logic [7:0] REG_BQ_B2    = 8'h09;
	localparam logic [7:0] REG_BQ_A1    = 8'h0A;
	localparam logic [7:0] REG_BQ_A2    = 8'h0B;
	localparam logic [7:0] REG_REINJ_L  = 8'h0C;
	localparam logic [7:0] REG_REINJ_R  = 8'h0D;
	localparam logic [7:0] REG_CTRL1    = 8'h0E;
	localparam logic [7:0] NUM_PRM      = 8'h0F;
	localparam logic [7:0] REG_LVL_MAIN = 8'h10;
	localparam logic [7:0] REG_LVL_SUB  = 8'h11;
	localparam int         TBL_SEL_BIT  = 7;
	localparam int         DM_LSB       = 4;

	localparam logic [14:0][21:0] PRM_RST = {
		22'h000000, 22'h000000, 22'h000000, 22'h000000, 22'h000000,
		22'h000000, 22'h000000, 22'h100000, 22'h080000, 22'h080000,
		22'h100000, 22'h000000, 22'h000000, 22'h000000, 22'h000100};

	// ----------------------------------------------------------------
	// dynamics constants
	// ----------------------------------------------------------------
	localparam int          FRAC        = 20;
	localparam int          LVL_FRAC    = 24;
	localparam logic [21:0] LOOKAHD_MAX = 22'h000064;
	localparam logic [2:0]  POST_STAGES = 3'h5;
	localparam logic [5:0]  GAIN_LAST   = 6'h20;
	localparam logic [5:0]  TBL_OFS     = 6'h0F;
	localparam logic [6:0]  TBL_SUB     = 7'h40;
	localparam longint      REL_MDB     = 137;
	localparam longint      IDX_MDB     = 3010;

	// ----------------------------------------------------------------
	// de-emphasis shelf 50 us pole / 15 us zero, bilinear per rate
	// ----------------------------------------------------------------
	localparam int        DM_POLE_NS = 50000;
	localparam int        DM_ZERO_NS = 15000;
	localparam ddp_coef_t DM32_B0    = 22'h077777;
	localparam ddp_coef_t DM32_B1    = 22'h002702;
	localparam ddp_coef_t DM32_FB    = 22'h086186;
	localparam ddp_coef_t DM44_B0    = 22'h06DEC6;
	localparam ddp_coef_t DM44_B1    = 22'h3F0B72;
	localparam ddp_coef_t DM44_FB    = 22'h0A15C3;
	localparam ddp_coef_t DM48_B0    = 22'h06BB26;
	localparam ddp_coef_t DM48_B1    = 22'h3EC944;
	localparam ddp_coef_t DM48_FB    = 22'h0A7B98;

	// ----------------------------------------------------------------
	// arithmetic
	// ----------------------------------------------------------------
	function automatic ddp_smp_t sat(logic signed [55:0] v);
		if (v > 56'sh7FFFFF)
			return 24'sh7FFFFF;
		if (v < -56'sh800000)
			return -24'sh800000;
		return v[23:0];
	endfunction : sat

	function automatic ddp_smp_t mulc(ddp_smp_t a, ddp_coef_t c);
		logic signed [55:0] p;
		p = a * c;
		return sat(p >>> FRAC);
	endfunction : mulc

endpackage : ddp_pkg

/* File: logic/ddp_mem.sv */
// Purpose: small one-write one-read memory, registered read data
// Assumes: read of the address written in the same cycle returns old data
// Notes:   contents are not reset
module ddp_mem #(
	parameter int W = 22,
	parameter int A = 7
) (
	// clock
	input  wire logic         i_core_clk,
	input  wire logic         i_resetn,
	input  wire logic         i_ce,
	// write side
	input  wire logic         i_we,
	input  wire logic [A-1:0] i_waddr,
	input  wire logic [W-1:0] i_wdata,
	// read side
	input  wire logic [A-1:0] i_raddr,
	output logic      [W-1:0] o_rdata
);
	import ddp_pkg::*;

	logic [W-1:0] mem [0:(1<<A)-1];
	logic [W-1:0] rd_q;

	always_ff @(posedge i_core_clk) begin
		if (i_ce && i_we)
			mem[i_waddr] <= i_wdata;
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn)
			rd_q <= '0;
		else if (i_ce)
			rd_q <= mem[i_raddr];
	end

	assign o_rdata = rd_q;

endmodule : ddp_mem

/* File: logic/ddp_deemph.sv */
// Purpose: first-order de-emphasis shelf on both main channels
// Assumes: one sample pair per i_vld pulse
// Notes:   bypass passes samples through one register stage
module ddp_deemph (
	// clock
	input  wire logic      i_core_clk,
	input  wire logic      i_resetn,
	input  wire logic      i_ce,
	// audio in
	input  wire logic      i_vld,
	input  ddp_pkg::ddp_pair_t i_smp,
	input  ddp_pkg::ddp_dm_e   i_sel,
	// audio out
	output logic           o_vld,
	output ddp_pkg::ddp_pair_t o_smp
);
	import ddp_pkg::*;

	typedef struct packed {
		ddp_pair_t x1;
		ddp_pair_t y1;
		ddp_pair_t out;
		logic      vld;
	} ddp_dm_st_t;

	ddp_dm_st_t q, d;
	ddp_coef_t  b0, b1, fb;
	ddp_smp_t   xv [2];
	ddp_smp_t   yv [2];
	logic signed [55:0] acc;

	always_comb begin
		d = q;
		acc = '0;
		d.vld = 1'b0;
		unique case (i_sel)
			DM_32K:  begin b0 = DM32_B0; b1 = DM32_B1; fb = DM32_FB; end
			DM_44K1: begin b0 = DM44_B0; b1 = DM44_B1; fb = DM44_FB; end
			DM_48K:  begin b0 = DM48_B0; b1 = DM48_B1; fb = DM48_FB; end
			DM_BYPASS: begin b0 = '0; b1 = '0; fb = '0; end
		endcase
		xv[0] = i_smp.l;
		xv[1] = i_smp.r;
		yv[0] = q.y1.l;
		yv[1] = q.y1.r;
		if (i_vld) begin
			d.vld = 1'b1;
			for (int c = 0; c < 2; c++) begin
				acc = xv[c] * b0;
				acc = acc + (c == 0 ? q.x1.l : q.x1.r) * b1;
				acc = acc + yv[c] * fb;
				yv[c] = (i_sel == DM_BYPASS) ? xv[c] : sat(acc >>> FRAC);
			end
			d.x1 = i_smp;
			d.y1 = {yv[0], yv[1]};
			d.out = {yv[0], yv[1]};
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn)
			q <= '0;
		else if (i_ce)
			q <= d;
	end

	assign o_vld = q.vld;
	assign o_smp = q.out;

endmodule : ddp_deemph

/* File: verification/ddp_top_props.sv */
// Purpose: port-level checks on the dynamics path
// Assumes: one clock domain, i_ce held high by the bench
// Notes:   bound into every ddp_top instance
module ddp_top_props
	import ddp_pkg::*;
(
	// clock and reset
	input wire logic          i_core_clk,
	input wire logic          i_resetn,
	input wire logic          i_ce,
	// register port
	input ddp_pkg::ddp_bus_t  i_bus,
	input wire logic [21:0]   o_rdata,
	// audio
	input wire logic          i_smp_vld,
	input ddp_pkg::ddp_pair_t i_smp,
	input wire logic          i_deemph_select_aux_input_pin,
	input wire logic          o_smp_vld,
	input ddp_pkg::ddp_pair_t o_smp,
	input ddp_pkg::ddp_smp_t  o_sub
);
	// ----------------------------------------------------------------
	// busy tracking
	// ----------------------------------------------------------------
	logic [4:0] busy_q;
	logic [4:0] busy_d;
	logic       take;

	assign take = i_smp_vld && i_ce && (busy_q == 5'h00);

	always_comb begin
		busy_d = busy_q;
		if (take)
			busy_d = 5'h12;
		else if (i_ce && busy_q != 5'h00)
			busy_d = busy_q - 5'h01;
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn)
			busy_q <= 5'h00;
		else
			busy_q <= busy_d;
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	// de-emphasis register adds one cycle after the core's output state
	smp_latency_a: assert property (take |-> ##18 o_smp_vld)
		else $error("result pulse late or missing");
	vld_origin_a: assert property (o_smp_vld |-> busy_q == 5'h01)
		else $error("result pulse without a taken sample");
	sub_lead_a: assert property ($changed(o_sub) |-> ##1 o_smp_vld)
		else $error("sub output moved outside its slot");
	smp_hold_a: assert property (!o_smp_vld |-> $stable(o_smp))
		else $error("main output moved without valid");
	rdata_hold_a: assert property (!$past(i_bus.rd) |-> $stable(o_rdata))
		else $error("read data moved without a read");
	unmapped_read_a: assert property (i_bus.rd && i_bus.addr > REG_LVL_SUB |=> o_rdata == 22'h000000)
		else $error("unmapped read not zero");
	write_readback_a: assert property (i_bus.wr && i_bus.addr < REG_LOOKAHD ##1
		i_bus.rd && i_bus.addr == $past(i_bus.addr) |=> o_rdata == $past(i_bus.wdata, 2))
		else $error("parameter read back differs");
	reset_out_a: assert property ($rose(i_resetn) |-> !o_smp_vld && o_sub == 24'h000000)
		else $error("outputs not cleared by reset");

	cover property (take);
	cover property (i_bus.rd && i_bus.addr >= 8'h80);
	cover property (o_smp_vld && i_deemph_select_aux_input_pin);
endmodule : ddp_top_props

bind ddp_top ddp_top_props u_props (
	.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_bus(i_bus),
	.o_rdata(o_rdata), .i_smp_vld(i_smp_vld), .i_smp(i_smp),
	.i_deemph_select_aux_input_pin(i_deemph_select_aux_input_pin),
	.o_smp_vld(o_smp_vld), .o_smp(o_smp), .o_sub(o_sub));

/* File: verification/ddp_host.sv */
// Purpose: host model loading and reading parameters
// Assumes: single-cycle strobes, read data one cycle later
// Notes:   released bus shows an inverted address; acc also inverts the data, wrrd leaves the written data
module ddp_host
	import ddp_pkg::*;
(
	// clock
	input wire logic          i_core_clk,
	// register port
	output ddp_pkg::ddp_bus_t o_bus,
	input wire logic [21:0]   i_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial o_bus = '0;

	task automatic acc(input logic [7:0] a, input logic [21:0] d, input logic w,
		output logic [21:0] q);
		if (w && a == REG_LOOKAHD && d > LOOKAHD_MAX)
			d = LOOKAHD_MAX;
		@(posedge i_core_clk);
		o_bus <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge i_core_clk);
		o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
		#1 q = i_rdata;
	endtask : acc

	task automatic wrrd(input logic [7:0] a, input logic [21:0] d, output logic [21:0] q);
		@(posedge i_core_clk);
		o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_core_clk);
		o_bus <= '{addr: a, wdata: ~d, wr: 1'b0, rd: 1'b1};
		@(posedge i_core_clk);
		o_bus <= '{addr: ~a, wdata: d, wr: 1'b0, rd: 1'b0};
		#1 q = i_rdata;
	endtask : wrrd
endmodule : ddp_host

/* File: verification/ddp_top_tb.sv */
// Purpose: self-checking bench for the dynamics path
// Assumes: all gain table entries loaded with unity gain
// Notes:   each de-emphasis case starts from reset so filter state is zero
module ddp_top_tb
	import ddp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        i_core_clk = 1'b0;
	logic        i_resetn   = 1'b0;
	logic        i_ce       = 1'b1;
	logic        i_smp_vld  = 1'b0;
	ddp_pair_t   i_smp      = '0;
	logic        pin        = 1'b0;
	ddp_bus_t    bus;
	logic [21:0] rdata;
	logic        o_smp_vld;
	ddp_pair_t   o_smp;
	ddp_smp_t    o_sub;
	int          miscompares = 0;
	int          num_checks  = 0;
	int          cyc         = 0;
	logic [21:0] q;
	logic [21:0] v0;
	ddp_pair_t   got;
	logic [21:0] dm_exp [6] = '{22'h100000, DM32_B0, DM44_B0, DM48_B0, DM44_B0, DM44_B0};
	logic [1:0]  dm_fld [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h3};

	always #5 i_core_clk = ~i_core_clk;

	ddp_top #(.FS_HZ(48000), .DLY_A(7)) DUT (
		.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_bus(bus),
		.o_rdata(rdata), .i_smp_vld(i_smp_vld), .i_smp(i_smp),
		.i_deemph_select_aux_input_pin(pin), .o_smp_vld(o_smp_vld), .o_smp(o_smp),
		.o_sub(o_sub));

	ddp_host host (.i_core_clk(i_core_clk), .o_bus(bus), .i_rdata(rdata));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [23:0] g, input logic [23:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check

	task automatic summarize();
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	// reset also clears the de-emphasis state for the next case
	task automatic restart();
		i_resetn <= 1'b0;
		repeat (8) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		for (int k = 0; k < 33; k++) begin
			host.acc(8'h80 + 8'(k), 22'h100000, 1'b1, q);
			host.acc(8'hC0 + 8'(k), 22'h100000, 1'b1, q);
		end
	endtask : restart

	task automatic samp(input ddp_smp_t l, input ddp_smp_t r, output ddp_pair_t y);
		int n = 0;
		@(posedge i_core_clk);
		i_smp_vld <= 1'b1;
		i_smp     <= '{l: l, r: r};
		@(posedge i_core_clk);
		i_smp_vld <= 1'b0;
		i_smp     <= '{l: ~l, r: ~r};
		do begin
			@(posedge i_core_clk);
			#1 n++;
		end while (o_smp_vld !== 1'b1 && n < 30);
		check({23'h0, o_smp_vld}, 24'h000001);
		y = o_smp;
	endtask : samp

	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, cyc, 0);
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		restart();
		for (int k = 0; k < 15; k++) begin
			host.acc(8'(k), 22'h0, 1'b0, q);
			check({2'h0, q}, k == 0 ? 24'h000100 : (k == 5 || k == 6) ? 24'h080000 :
				(k == 4 || k == 7) ? 24'h100000 : 24'h000000);
		end
		host.wrrd(REG_TCONST, 22'h3FFFFF, q);
		check({2'h0, q}, 24'h3FFFFF);
		host.acc(NUM_PRM, 22'h155555, 1'b1, q);
		foreach (dm_fld[k]) begin
			host.acc(k[0] ? 8'h90 : 8'h20 + 8'(k), 22'h0, 1'b0, q);
			check({2'h0, q}, 24'h0);
		end
		host.acc(NUM_PRM, 22'h0, 1'b0, q);
		check({2'h0, q}, 24'h0);
		// detector hold then release
		host.wrrd(REG_TCONST, 22'h100000, q);
		host.wrrd(REG_HOLD, 22'h000004, q);
		host.wrrd(REG_DECAY, 22'h0003E8, q);
		samp(24'h400000, 24'h400000, got);
		host.acc(REG_LVL_MAIN, 22'h0, 1'b0, v0);
		check({23'h0, v0 != 22'h0}, 24'h1);
		for (int k = 1; k <= 8; k++) begin
			samp(24'h0, 24'h0, got);
			host.acc(REG_LVL_MAIN, 22'h0, 1'b0, q);
			if (k <= 4)
				check({2'h0, q}, {2'h0, v0});
		end
		check({23'h0, q < v0}, 24'h1);
		// post gain, weights, reinjection, look-ahead
		restart();
		host.acc(REG_POSTGAIN, 22'h180000, 1'b1, q);
		samp(24'h010000, 24'h0, got);
		check(got.l, 24'h079800);
		check(o_sub, 24'h008000);
		host.acc(REG_POSTGAIN, 22'h100000, 1'b1, q);
		host.acc(REG_REINJ_L, 22'h080000, 1'b1, q);
		samp(24'h100000, 24'h040000, got);
		check(o_sub, 24'h0A0000);
		check(got.l, 24'h150000);
		check(got.r, 24'h040000);
		host.acc(REG_REINJ_L, 22'h0, 1'b1, q);
		host.acc(REG_LOOKAHD, 22'h000003, 1'b1, q);
		for (int k = 1; k <= 6; k++) begin
			samp(24'(k * 24'h1000), 24'h0, got);
			if (k >= 4)
				check(got.l, 24'((k - 3) * 24'h1000));
			check(o_sub, 24'(k * 24'h800));
		end
		// de-emphasis curves, field and pin
		for (int m = 0; m < 6; m++) begin
			restart();
			pin <= (m >= 4);
			host.acc(REG_CTRL1, {16'h0, dm_fld[m], 4'h0}, 1'b1, q);
			samp(24'h100000, 24'h040000, got);
			check(got.l, {2'h0, dm_exp[m]});
			check(got.r, {2'h0, dm_exp[m]} >> 2);
		end
		summarize();
	end
endmodule : ddp_top_tb
